// ### rtl/spkamp_dev.sv
// Amplifier control slave: two-wire receiver and the control register.
// Functional notes
// - Link works at serial rates to 400 kHz.
// - Master keeps data steady while clock high.
// - Slave never drives clock; master makes it.
// - Transfers framed by start and stop.
// - Eight bit bytes, each with acknowledge.
// - Data falling with clock high is start.
// - Address 1110110 sent first, MSB first.
// - Writes only; read direction gets no answer.
// - Bits sampled on serial clock rising edge.
// - Matching address acknowledged on ninth clock.
// - Data byte acknowledged on following clock.
// - Data rising with clock high is stop.
// - Gain bits 7..3, enables bits 1, 0.
// - Gain code maps 32 steps, -70..+24 dB.
// - Both enables zero shutdown, both one run.
// - Shutdown keeps the stored gain code.
// - Reset clears register to shutdown, gain 0.
// - During reset bus traffic is ignored.
// - After reset stays shut down at minimum gain.
// - Power loss clears register like reset.
//
// Timing notes for whoever drives this slave.
// The serial clock is an ordinary input here, not a clock. Both lines pass
// two flops, and a third stage gives the previous level for edge finding.
// An edge on either line is therefore seen two to three system cycles
// late. The master must keep each half period of the serial clock well
// above that delay; four system cycles is the least this logic can serve.
// At a 50 MHz system clock a 400 kHz link leaves ample margin.
// Start and stop are found only while the clock has been high for two
// samples, so a data change right after a clock edge is not mistaken for
// a frame marker. The master must keep data steady while the clock is
// high, otherwise a stray start or stop is seen.
// The acknowledge is driven from a register, so it rises and falls a few
// cycles after the synchronised falling clock edge, always while the
// clock is low, and never overlaps a clock high edge with a change.
// A refused address, wrong in value or with the read direction set,
// parks the receiver until the next start. The register is not touched.
// The control register loads at the falling edge after the eighth data
// bit. A frame cut before that point changes nothing.
// The gain code is handed out as the raw five bit code. The analog gain
// network maps it to dB; the package table gives the mapping for tests.
module spkamp_dev (
  input wire logic mclk,
  input wire logic rst,
  spkamp_if.dev bus,
  output logic [4:0] gain_code,
  output logic enable_a,
  output logic enable_b,
  output logic amp_on,
  output logic write_done,
  output logic [7:0] ctrl_value
);
  typedef enum {SPKAMP_IDLE, SPKAMP_ADDR, SPKAMP_AACK, SPKAMP_DATA,
                SPKAMP_DACK, SPKAMP_WAIT} spkamp_dev_state_t;

  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  spkamp_dev_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] ctrl_reg;
  logic ack_drive_reg;
  logic data_byte_end;

  // True at the falling clock edge that closes the eighth bit of a byte.
  function automatic logic byte_closed(input logic fall,
                                       input logic [3:0] cnt);
    return fall && cnt == 4'(spkamp_pkg::SPKAMP_BYTE_BITS);
  endfunction

  // The data byte is complete; used for the register load and its pulse.
  assign data_byte_end = state_reg == SPKAMP_DATA &&
                         byte_closed(scl_fall, bit_cnt_reg);

  // Two flops on each pin; the serial clock is sampled, not used as a clock.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end

  // Edge and framing detection on the synchronised levels.
  assign scl_rise = scl_sync_reg[1] && !scl_d_reg;
  assign scl_fall = !scl_sync_reg[1] && scl_d_reg;
  assign start_det = scl_sync_reg[1] && scl_d_reg && sda_d_reg &&
                     !sda_sync_reg[1];
  assign stop_det = scl_sync_reg[1] && scl_d_reg && !sda_d_reg &&
                    sda_sync_reg[1];

  // Byte framing. Reset holds everything idle so no traffic is seen.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= SPKAMP_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
    end else if (start_det) begin
      state_reg <= SPKAMP_ADDR;
      bit_cnt_reg <= 4'h0;
    end else if (stop_det) begin
      state_reg <= SPKAMP_IDLE;
    end else begin
      unique case (state_reg)
        SPKAMP_IDLE, SPKAMP_WAIT: begin
        end
        SPKAMP_ADDR, SPKAMP_DATA: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (byte_closed(scl_fall, bit_cnt_reg)) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == SPKAMP_DATA) begin
              state_reg <= SPKAMP_DACK;
            end else if (shift_reg == {spkamp_pkg::SPKAMP_DEV_ADDR, 1'b0})
            begin
              state_reg <= SPKAMP_AACK;
            end else begin
              state_reg <= SPKAMP_WAIT;
            end
          end
        end
        SPKAMP_AACK: begin
          if (scl_fall) begin
            state_reg <= SPKAMP_DATA;
          end
        end
        SPKAMP_DACK: begin
          if (scl_fall) begin
            state_reg <= SPKAMP_WAIT;
          end
        end
      endcase
    end
  end

  // Acknowledge drive: only the data line, never the clock.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_drive_reg <= 1'b0;
    end else begin
      ack_drive_reg <= (state_reg == SPKAMP_AACK ||
                        state_reg == SPKAMP_DACK) &&
                       !start_det && !stop_det;
    end
  end

  // The register loads whole bytes only, at the end of the eighth bit.
  // Reset also covers power-up, since flops start from this value.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= spkamp_pkg::SPKAMP_CTRL_RESET;
    end else if (data_byte_end) begin
      ctrl_reg <= shift_reg;
    end
  end

  // Registered outputs; shutdown leaves the gain code untouched.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gain_code <= 5'h00;
      enable_a <= 1'b0;
      enable_b <= 1'b0;
      amp_on <= 1'b0;
      write_done <= 1'b0;
      ctrl_value <= 8'h00;
    end else begin
      gain_code <= ctrl_reg[spkamp_pkg::SPKAMP_GAIN_MSB:
                            spkamp_pkg::SPKAMP_GAIN_LSB];
      enable_a <= ctrl_reg[spkamp_pkg::SPKAMP_EN_A_BIT];
      enable_b <= ctrl_reg[spkamp_pkg::SPKAMP_EN_B_BIT];
      // Amplifier runs only when both enables are set.
      amp_on <= ctrl_reg[spkamp_pkg::SPKAMP_EN_A_BIT] &&
                ctrl_reg[spkamp_pkg::SPKAMP_EN_B_BIT];
      write_done <= data_byte_end;
      ctrl_value <= ctrl_reg;
    end
  end

  assign bus.sda_o_dev = 1'b0;
  assign bus.sda_oe_n_dev = !ack_drive_reg;
endmodule

// ### inc/spkamp_pkg.sv
// Shared constants for the speaker amplifier two-wire control link.
package spkamp_pkg;
  localparam logic [6:0] SPKAMP_DEV_ADDR = 7'h76;
  localparam int SPKAMP_BYTE_BITS = 8;
  localparam int SPKAMP_GAIN_MSB = 7;
  localparam int SPKAMP_GAIN_LSB = 3;
  localparam int SPKAMP_ZERO_BIT = 2;
  localparam int SPKAMP_EN_A_BIT = 1;
  localparam int SPKAMP_EN_B_BIT = 0;
  localparam logic [7:0] SPKAMP_CTRL_RESET = 8'h00;
  localparam int SPKAMP_SYNC_STAGES = 2;
  // Fastest serial clock rate and the system clock frequency in MHz.
  localparam int SPKAMP_MAX_RATE_KHZ = 400;
  localparam int SPKAMP_MCLK_MHZ = 50;
  // Half serial clock period in system cycles, rounded up.
  localparam int SPKAMP_HALF_CYC =
    (SPKAMP_MCLK_MHZ * 1000 + 2 * SPKAMP_MAX_RATE_KHZ - 1) /
    (2 * SPKAMP_MAX_RATE_KHZ);
  // Gain in dB for each of the 32 codes, code 0 first.
  function automatic int spkamp_gain_db(input logic [4:0] code);
    int tbl [32];
    tbl = '{-70, -56, -46, -38, -32, -28, -24, -21, -18, -15, -12, -10,
            -8, -6, -4, -2, 0, 2, 4, 6, 8, 10, 12, 14, 16, 18, 19, 20,
            21, 22, 23, 24};
    return tbl[code];
  endfunction
endpackage

// ### inc/spkamp_if.sv
// Two-wire link between the host master and the amplifier control slave.
`timescale 1ns/1ps
interface spkamp_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_o;
  logic sda_oe_n;
  logic sda_o_dev;
  logic sda_oe_n_dev;
  wire scl;
  wire sda;
  // Open-drain resolution: any enabled driver low pulls the line low.
  assign scl = (!scl_oe_n && !scl_o) ? 1'b0 : 1'b1;
  assign sda = ((!sda_oe_n && !sda_o) || (!sda_oe_n_dev && !sda_o_dev)) ?
               1'b0 : 1'b1;
  modport host (output scl_o, output scl_oe_n, output sda_o,
                output sda_oe_n, input scl, input sda);
  modport dev (output sda_o_dev, output sda_oe_n_dev, input scl,
               input sda);
endinterface

// ### rtl/spkamp_host.sv
// Host master: sends one address byte and one control byte per request.
`timescale 1ns/1ps
module spkamp_host #(
  parameter int HALF_CYC = spkamp_pkg::SPKAMP_HALF_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  spkamp_if.host bus,
  input wire logic req,
  input wire logic [7:0] wdata,
  input wire logic read_dir,
  output logic busy,
  output logic done,
  output logic nack
);
  typedef enum {SPKAMP_H_IDLE, SPKAMP_H_START, SPKAMP_H_BIT,
                SPKAMP_H_STOP} spkamp_host_state_t;

  initial begin
    if (HALF_CYC < 2) $error("HALF_CYC too small");
  end

  spkamp_host_state_t state_reg;
  logic [15:0] cnt_reg;
  logic [1:0] phase_reg;
  logic [4:0] bit_reg;
  logic [17:0] frame_reg;
  logic scl_reg;
  logic sda_reg;
  logic [1:0] sda_sync_reg;
  logic nack_reg;
  logic tick;

  assign tick = cnt_reg == 16'(HALF_CYC - 1);

  // Data line read back through two flops to see acknowledges.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sda_sync_reg <= 2'h3;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
    end
  end

  // Quarter-period divider; the host alone makes the serial clock.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 16'h0000;
    end else if (state_reg == SPKAMP_H_IDLE) begin
      // Idle restarts the divider so every frame opens with a full phase.
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= tick ? 16'h0000 : cnt_reg + 16'h0001;
    end
  end

  // Frame: start, 18 clocked bits (address, ack, data, ack), stop.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= SPKAMP_H_IDLE;
      phase_reg <= 2'h0;
      bit_reg <= 5'h00;
      frame_reg <= 18'h00000;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      nack_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state_reg)
        SPKAMP_H_IDLE: begin
          if (req) begin
            frame_reg <= {spkamp_pkg::SPKAMP_DEV_ADDR, read_dir, 1'b1,
                          wdata, 1'b1};
            nack_reg <= 1'b0;
            state_reg <= SPKAMP_H_START;
          end
        end
        SPKAMP_H_START: begin
          if (tick) begin
            sda_reg <= 1'b0;
            phase_reg <= 2'h0;
            bit_reg <= 5'h00;
            state_reg <= SPKAMP_H_BIT;
          end
        end
        SPKAMP_H_BIT: begin
          if (tick) begin
            phase_reg <= phase_reg + 2'h1;
            unique case (phase_reg)
              2'h0: scl_reg <= 1'b0;
              // Data changes only while the clock is low.
              2'h1: sda_reg <= frame_reg[17];
              2'h2: scl_reg <= 1'b1;
              2'h3: begin
                if ((bit_reg == 5'd8 || bit_reg == 5'd17) &&
                    sda_sync_reg[1]) begin
                  nack_reg <= 1'b1;
                end
                frame_reg <= {frame_reg[16:0], 1'b1};
                bit_reg <= bit_reg + 5'h01;
                if (bit_reg == 5'd17) begin
                  state_reg <= SPKAMP_H_STOP;
                  phase_reg <= 2'h0;
                end
              end
            endcase
          end
        end
        SPKAMP_H_STOP: begin
          if (tick) begin
            phase_reg <= phase_reg + 2'h1;
            unique case (phase_reg)
              2'h0: scl_reg <= 1'b0;
              2'h1: sda_reg <= 1'b0;
              2'h2: scl_reg <= 1'b1;
              2'h3: begin
                sda_reg <= 1'b1;
                done <= 1'b1;
                state_reg <= SPKAMP_H_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Status outputs, registered.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      nack <= 1'b0;
    end else begin
      busy <= state_reg != SPKAMP_H_IDLE || req;
      nack <= nack_reg;
    end
  end

  // Open drain: low is driven, high is released.
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe_n = scl_reg;
  assign bus.sda_o = 1'b0;
  assign bus.sda_oe_n = sda_reg;
endmodule

// ### verif/spkamp_chk.sv
// Link checker for the host master and amplifier slave.
`timescale 1ns/1ps
module spkamp_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_oe_n,
  input wire logic sda_oe_n_dev
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic scl_q;
  logic sda_q;
  logic [4:0] pulse_cnt;
  logic start_ev;
  logic stop_ev;
  logic hi_move;
  // A data edge while the clock stays high marks start or stop.
  assign hi_move = scl && scl_q && (sda != sda_q);
  assign start_ev = hi_move && !sda;
  assign stop_ev = hi_move && sda;
  // Line history; released lines idle high.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // Clock pulses since start; saturates so a runaway never wraps.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pulse_cnt <= 5'h00;
    end else if (start_ev) begin
      pulse_cnt <= 5'h00;
    end else if (scl && !scl_q && pulse_cnt != 5'h1f) begin
      pulse_cnt <= pulse_cnt + 5'h01;
    end
  end
  // The stop's own clock rise follows the 18 bit clocks, so 19 pulses.
  a_start_hold: assert property (start_ev |-> scl [*5])
    else $error("clock fell too soon after start");
  a_byte_count: assert property (stop_ev |-> pulse_cnt == 5'h13)
    else $error("stop after a partial byte");
  a_data_steady: assert property (hi_move |->
    (pulse_cnt == 5'h00 || pulse_cnt == 5'h13))
    else $error("data moved while clock high mid byte");
  a_ack_clock_low: assert property ($changed(sda_oe_n_dev) |-> !scl)
    else $error("acknowledge changed while clock high");
  a_host_released: assert property (!sda_oe_n_dev && scl |-> sda_oe_n)
    else $error("master drove data during acknowledge");
  a_ack_spans: assert property ($fell(sda_oe_n_dev) |->
    ##[1:40] (scl && !sda_oe_n_dev))
    else $error("acknowledge not held over a clock high");
  a_ack_bounded: assert property ($fell(sda_oe_n_dev) |->
    ##[1:64] sda_oe_n_dev)
    else $error("acknowledge never released");
  a_scl_high_w: assert property ($rose(scl) |-> scl [*4])
    else $error("clock high phase too short");
  a_scl_low_w: assert property ($fell(scl) |-> !scl [*4])
    else $error("clock low phase too short");
  c_start: cover property (start_ev);
  c_full_write: cover property (stop_ev && pulse_cnt == 5'h13);
  c_ack: cover property ($fell(sda_oe_n_dev));
endmodule

// ### verif/test_speaker_amp_i2c_control.sv
// Self-checking bench: host master and amplifier slave on one link.
`timescale 1ns/1ps
module test_speaker_amp_i2c_control;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic read_dir = 1'b0;
  logic busy, done, nack, amp_on, write_done, enable_a, enable_b;
  logic [4:0] gain_code;
  logic [7:0] ctrl_value;
  int err_count = 0;
  int n_tests = 0;
  int wd_seen;
  spkamp_if lnk();
  // Short half period keeps each frame to a few hundred cycles.
  spkamp_host #(.HALF_CYC(8)) spkamp_host_i (.mclk(mclk), .rst(rst),
    .bus(lnk), .req(req), .wdata(wdata), .read_dir(read_dir),
    .busy(busy), .done(done), .nack(nack));
  spkamp_dev spkamp_dev_i (.mclk(mclk), .rst(rst), .bus(lnk),
    .gain_code(gain_code), .enable_a(enable_a), .enable_b(enable_b),
    .amp_on(amp_on), .write_done(write_done), .ctrl_value(ctrl_value));
  spkamp_chk spkamp_chk_i (.mclk(mclk), .rst(rst), .scl(lnk.scl),
    .sda(lnk.sda), .sda_oe_n(lnk.sda_oe_n),
    .sda_oe_n_dev(lnk.sda_oe_n_dev));
  // Clock at 50 MHz.
  always #10 mclk = ~mclk;
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Compares every register output with the byte expected in it.
  task automatic chk_reg(input logic [7:0] d);
    chk(ctrl_value, d, "ctrl");
    chk({3'h0, gain_code}, {3'h0, d[7:3]}, "gain");
    chk({7'h00, enable_a}, {7'h00, d[1]}, "en_a");
    chk({7'h00, enable_b}, {7'h00, d[0]}, "en_b");
    chk({7'h00, amp_on}, {7'h00, d[1] & d[0]}, "amp_on");
  endtask
  // One request; counts stored bytes until done, with a bounded wait.
  task automatic send(input logic [7:0] d, input logic rd);
    int i;
    wd_seen = 0;
    @(negedge mclk);
    req = 1'b1;
    wdata = d;
    read_dir = rd;
    @(negedge mclk);
    req = 1'b0;
    for (i = 0; i < 4000 && done !== 1'b1; i++) begin
      @(negedge mclk);
      if (write_done === 1'b1) wd_seen++;
    end
    if (done !== 1'b1) begin
      err_count++;
      $display("MISMATCH t=%0t no done", $time);
      test_done();
    end
  endtask
  // Back-to-back writes: full gain, shutdown keeping gain, mixed enables.
  task automatic t_writes();
    logic [7:0] tbl [5];
    tbl = '{8'hfb, 8'hf8, 8'h03, 8'h7a, 8'h81};
    foreach (tbl[k]) begin
      send(tbl[k], 1'b0);
      chk(wd_seen[7:0], 8'h01, "stored");
      chk({7'h00, nack}, 8'h00, "nack");
      chk_reg(tbl[k]);
    end
  endtask
  // Read direction is refused; the next write recovers.
  task automatic t_read_refused();
    send(8'h55, 1'b1);
    chk({7'h00, nack}, 8'h01, "read nack");
    chk(wd_seen[7:0], 8'h00, "read stored");
    chk_reg(8'h81);
    send(8'h8b, 1'b0);
    chk({7'h00, nack}, 8'h00, "nack clear");
    chk_reg(8'h8b);
  endtask
  // Reset in the middle of the data byte clears and stores nothing.
  task automatic t_reset_mid();
    @(negedge mclk);
    req = 1'b1;
    wdata = 8'h33;
    @(negedge mclk);
    req = 1'b0;
    repeat (400) @(negedge mclk);
    rst = 1'b1;
    repeat (3) @(negedge mclk);
    chk_reg(8'h00);
    rst = 1'b0;
    repeat (700) @(negedge mclk);
    chk_reg(8'h00);
    send(8'h0b, 1'b0);
    chk_reg(8'h0b);
  endtask
  initial begin
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    chk_reg(8'h00);
    t_writes();
    t_read_refused();
    t_reset_mid();
    test_done();
  end
endmodule
